// ---- stop_mode_pkg.sv ----
// Constants, types and register map of the stop mode controller
package stop_mode_pkg;

    // Timing: clock period and machine cycle (one gear clock period)
    localparam int unsigned CLK_NS    = 50;
    localparam int unsigned MC_NS     = 50;
    localparam int unsigned MC_CYCLES = (MC_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0]  LOW_DIV_M1 = 2'h3;

    // Warm-up counter: duration register scaled by a fixed shift
    localparam int unsigned WU_SHIFT  = 4;
    localparam int unsigned WU_W      = 8 + WU_SHIFT;
    localparam logic [WU_W-1:0] RST_WARM_CNT = 12'h100;

    // Register byte offsets
    localparam logic [5:0] SCO_OFS  = 6'h00;
    localparam logic [5:0] WCC_OFS  = 6'h04;
    localparam logic [5:0] WCD_OFS  = 6'h08;
    localparam logic [5:0] MODE_OFS = 6'h0C;
    localparam logic [5:0] STAT_OFS = 6'h10;
    localparam logic [5:0] INT_OFS  = 6'h14;

    // Field positions
    localparam int unsigned STOP_BIT = 7;
    localparam int unsigned WAKE_RELEASE_SELECT_BIT = 6;
    localparam int unsigned HOLD_BIT = 4;
    localparam int unsigned WSEL_BIT = 0;
    localparam int unsigned WDT_BIT  = 2;
    localparam int unsigned ICLR_BIT = 0;

    // Reset values
    localparam logic [7:0] WCD_RST = 8'h10;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_STOP = 2'b01,
        ST_WARM = 2'b11
    } pm_state_e;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_DUAL   = 2'b01,
        MODE_LOW    = 2'b10
    } run_mode_e;

    typedef struct packed {
        logic hi_osc_en;
        logic lo_osc_en;
        logic core_hold;
        logic port_hold;
        logic cpu_clk_gear;
        logic wdt_clk_low;
        logic warmup_src_lo;
    } clk_ctrl_s;

endpackage

// ---- stop_mode_controller.sv ----
// Stop mode entry, wake and warm-up sequencing with an Avalon-MM register slave
`timescale 1ns/1ns
`default_nettype none

module stop_mode_controller
    import stop_mode_pkg::*;
(
    // Clock and reset
    input  wire  logic        ref_clk,
    input  wire  logic        reset,
    // Avalon-MM slave
    input  wire  logic [5:0]  avs_address,
    input  wire  logic        avs_read,
    input  wire  logic        avs_write,
    input  wire  logic [31:0] avs_writedata,
    input  wire  logic [3:0]  avs_byteenable,
    output logic [31:0]       avs_readdata,
    output logic              avs_waitrequest,
    // Wake pins, asynchronous
    input  wire  logic        stop_pin,
    input  wire  logic        key_wake,
    input  wire  logic        volt_wake,
    // Core side
    input  wire  logic [15:0] instr_addr,
    output logic [15:0]       resume_pc_q,
    output logic              tg_clear_q,
    output logic              mcyc_tick_q,
    output logic              int_latch_q,
    output clk_ctrl_s         clk_ctrl_q
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helper

    function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
        hit = (a[5:2] == ofs[5:2]);
    endfunction

    pm_state_e   state_q;
    run_mode_e   mode_q;
    run_mode_e   saved_mode_q;
    logic [2:0]  sync1_q;
    logic [2:0]  sync2_q;
    logic        pin_prev_q;
    logic        wake_release_select_q;
    logic        hold_q;
    logic        wsel_q;
    logic        wdt_sel_q;
    logic [7:0]  wcd_q;
    logic [WU_W-1:0] warm_cnt_q;
    logic [1:0]  mc_cnt_q;
    logic        blind_q;
    logic        ack_q;
    logic        wr_fire;
    logic        entry;
    logic        pin_s;
    logic        pin_rise;
    logic        pin_fall;
    logic        wake;
    logic        warm_done;

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers on the always-on clock

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= (gi == 0) ? stop_pin : (gi == 1) ? key_wake : volt_wake;
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    assign pin_s = sync2_q[0];

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_s;
        end
    end

    assign pin_rise = pin_s & ~pin_prev_q;
    assign pin_fall = ~pin_s & pin_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait state, write takes effect on the answer edge

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_fire = avs_write & ack_q & avs_byteenable[0] & (state_q == ST_RUN);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & ~ack_q) begin
            avs_readdata <= 32'h0000_0000;
            if (hit(avs_address, SCO_OFS)) begin
                avs_readdata[STOP_BIT] <= (state_q == ST_STOP);
                avs_readdata[WAKE_RELEASE_SELECT_BIT] <= wake_release_select_q;
                avs_readdata[HOLD_BIT] <= hold_q;
            end else if (hit(avs_address, WCC_OFS)) begin
                avs_readdata[WSEL_BIT] <= wsel_q;
            end else if (hit(avs_address, WCD_OFS)) begin
                avs_readdata[7:0] <= wcd_q;
            end else if (hit(avs_address, MODE_OFS)) begin
                avs_readdata[1:0] <= mode_q;
                avs_readdata[WDT_BIT] <= wdt_sel_q;
            end else if (hit(avs_address, STAT_OFS)) begin
                avs_readdata[7:0] <= {pin_s, sync2_q[1], sync2_q[2], int_latch_q,
                                      state_q, clk_ctrl_q.hi_osc_en, clk_ctrl_q.lo_osc_en};
            end else if (hit(avs_address, INT_OFS)) begin
                avs_readdata[ICLR_BIT] <= int_latch_q;
            end
        end
    end

    // Configuration registers; the core is halted outside run, so writes are dropped then
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wake_release_select_q    <= 1'b0;
            hold_q    <= 1'b0;
            wsel_q    <= 1'b0;
            wdt_sel_q <= 1'b0;
            wcd_q     <= WCD_RST;
            mode_q    <= MODE_SINGLE;
        end else if (wr_fire) begin
            if (hit(avs_address, SCO_OFS)) begin
                wake_release_select_q <= avs_writedata[WAKE_RELEASE_SELECT_BIT];
                hold_q <= avs_writedata[HOLD_BIT];
            end
            if (hit(avs_address, WCC_OFS)) begin
                wsel_q <= avs_writedata[WSEL_BIT];
            end
            if (hit(avs_address, WCD_OFS)) begin
                wcd_q <= avs_writedata[7:0];
            end
            if (hit(avs_address, MODE_OFS) && avs_writedata[1:0] != 2'h3) begin
                mode_q    <= run_mode_e'(avs_writedata[1:0]);
                wdt_sel_q <= avs_writedata[WDT_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stop sequencing

    // New release select applies to the same write that sets the stop bit
    assign entry = wr_fire & hit(avs_address, SCO_OFS) & avs_writedata[STOP_BIT]
                 & ~(avs_writedata[WAKE_RELEASE_SELECT_BIT] & pin_s);

    assign wake = (wake_release_select_q ? pin_s : (pin_rise & ~blind_q))
                | sync2_q[1] | sync2_q[2];

    assign warm_done = (state_q == ST_WARM) && (warm_cnt_q == '0);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_WARM;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (entry) begin
                        state_q <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (wake) begin
                        state_q <= ST_WARM;
                    end
                end
                ST_WARM: begin
                    if (warm_done) begin
                        state_q <= ST_RUN;
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    // Edges seen within one machine cycle after the request are masked
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            blind_q <= 1'b0;
        end else begin
            blind_q <= entry && (MC_CYCLES >= 1);
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            warm_cnt_q <= RST_WARM_CNT;
        end else if (state_q == ST_STOP && wake) begin
            warm_cnt_q <= {wcd_q, {WU_SHIFT{1'b0}}};
        end else if (state_q == ST_WARM && warm_cnt_q != '0) begin
            warm_cnt_q <= warm_cnt_q - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            saved_mode_q <= MODE_SINGLE;
            resume_pc_q  <= 16'h0000;
        end else if (entry) begin
            saved_mode_q <= mode_q;
            resume_pc_q  <= instr_addr + 16'h0002;
        end
    end

    // Prescaler and divider clear at entry and again as run resumes
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tg_clear_q <= 1'b0;
        end else begin
            tg_clear_q <= entry | warm_done;
        end
    end

    // Falling edge of the shared pin is the external interrupt; set wins over clear
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            int_latch_q <= 1'b0;
        end else if (pin_fall) begin
            int_latch_q <= 1'b1;
        end else if (wr_fire && hit(avs_address, INT_OFS) && avs_writedata[ICLR_BIT]) begin
            int_latch_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock controls, one cycle behind the state

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            clk_ctrl_q <= '0;
        end else begin
            clk_ctrl_q.hi_osc_en     <= (state_q != ST_STOP) && (saved_mode_q != MODE_LOW);
            clk_ctrl_q.lo_osc_en     <= (state_q != ST_STOP) && (saved_mode_q != MODE_SINGLE);
            clk_ctrl_q.core_hold     <= (state_q != ST_RUN);
            clk_ctrl_q.port_hold     <= (state_q == ST_STOP) && hold_q;
            clk_ctrl_q.cpu_clk_gear  <= (mode_q != MODE_LOW);
            clk_ctrl_q.wdt_clk_low   <= (mode_q == MODE_LOW) || (mode_q == MODE_DUAL && wdt_sel_q);
            clk_ctrl_q.warmup_src_lo <= (saved_mode_q == MODE_LOW);
        end
    end

    // Machine cycle tick: every gear clock, or every fourth in low-clock run
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mc_cnt_q    <= 2'h0;
            mcyc_tick_q <= 1'b0;
        end else if (state_q != ST_RUN) begin
            mc_cnt_q    <= 2'h0;
            mcyc_tick_q <= 1'b0;
        end else if (mode_q != MODE_LOW) begin
            mc_cnt_q    <= 2'h0;
            mcyc_tick_q <= 1'b1;
        end else begin
            mc_cnt_q    <= (mc_cnt_q == LOW_DIV_M1) ? 2'h0 : mc_cnt_q + 2'h1;
            mcyc_tick_q <= (mc_cnt_q == LOW_DIV_M1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_enter;
        @(posedge ref_clk) disable iff (reset) entry |=> state_q == ST_STOP;
    endproperty
    a_enter: assert property (p_enter) else $error("stop not entered");

    property p_osc_off;
        @(posedge ref_clk) disable iff (reset)
            (state_q == ST_STOP) && $past(state_q == ST_STOP)
            |-> !clk_ctrl_q.hi_osc_en && !clk_ctrl_q.lo_osc_en && clk_ctrl_q.core_hold;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator running in stop");

    property p_level_block;
        @(posedge ref_clk) disable iff (reset)
            wr_fire && hit(avs_address, SCO_OFS) && avs_writedata[STOP_BIT]
            && avs_writedata[WAKE_RELEASE_SELECT_BIT] && pin_s |=> state_q == ST_RUN;
    endproperty
    a_level_block: assert property (p_level_block) else $error("stop taken with pin high");

    property p_edge_honour;
        @(posedge ref_clk) disable iff (reset)
            wr_fire && hit(avs_address, SCO_OFS) && avs_writedata[STOP_BIT]
            && !avs_writedata[WAKE_RELEASE_SELECT_BIT] |=> state_q == ST_STOP;
    endproperty
    a_edge_honour: assert property (p_edge_honour) else $error("edge mode request lost");

    property p_pc;
        @(posedge ref_clk) disable iff (reset)
            entry |=> tg_clear_q && resume_pc_q == $past(instr_addr) + 16'h0002;
    endproperty
    a_pc: assert property (p_pc) else $error("resume address or clear wrong");

    property p_level_wake;
        @(posedge ref_clk) disable iff (reset)
            state_q == ST_STOP && wake_release_select_q && pin_s |=> state_q == ST_WARM;
    endproperty
    a_level_wake: assert property (p_level_wake) else $error("level wake missed");

    property p_no_return;
        @(posedge ref_clk) disable iff (reset)
            state_q == ST_WARM && !warm_done |=> state_q == ST_WARM;
    endproperty
    a_no_return: assert property (p_no_return) else $error("warm-up left early");

    property p_blind;
        @(posedge ref_clk) disable iff (reset)
            state_q == ST_STOP && blind_q && !wake_release_select_q && !sync2_q[1] && !sync2_q[2]
            |=> state_q == ST_STOP;
    endproperty
    a_blind: assert property (p_blind) else $error("early edge released stop");

    property p_edge_wake;
        @(posedge ref_clk) disable iff (reset)
            state_q == ST_STOP && !wake_release_select_q && pin_rise && !blind_q
            |=> state_q == ST_WARM ##1 clk_ctrl_q.warmup_src_lo == (saved_mode_q == MODE_LOW);
    endproperty
    a_edge_wake: assert property (p_edge_wake) else $error("edge wake or source wrong");

    c_level_cycle: cover property (@(posedge ref_clk) disable iff (reset)
        state_q == ST_STOP && wake_release_select_q ##1 state_q == ST_WARM);
    c_edge_cycle: cover property (@(posedge ref_clk) disable iff (reset)
        state_q == ST_STOP && !wake_release_select_q && pin_rise);
    c_resume: cover property (@(posedge ref_clk) disable iff (reset)
        warm_done && saved_mode_q == MODE_DUAL);

endmodule

`default_nettype wire

// ---- stop_pin_source.sv ----
// Wake source model that drives the stop pin
`timescale 1ns/1ns
`default_nettype none

module stop_pin_source (
    // Clock
    input  wire logic       ref_clk,
    // Command from the bench
    input  wire logic       want_high,
    input  wire logic [3:0] lag,
    // Pin
    output var  logic       stop_pin
);
    logic [3:0] cnt_q;

    initial begin
        stop_pin = 1'b0;
        cnt_q    = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin moves only after the chosen lag, whatever the controller is doing
    always @(posedge ref_clk) begin
        if (want_high == stop_pin) begin
            cnt_q <= 4'h0;
        end else if (cnt_q >= lag) begin
            stop_pin <= want_high;
            cnt_q    <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the stop mode controller
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import stop_mode_pkg::*;

    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        stop_pin;
    logic        key_wake = 1'b0;
    logic        volt_wake = 1'b0;
    logic [15:0] instr_addr = 16'h0000;
    logic [15:0] resume_pc_q;
    logic        tg_clear_q;
    logic        mcyc_tick_q;
    logic        int_latch_q;
    clk_ctrl_s   clk_ctrl_q;
    logic        want_high = 1'b0;
    logic [3:0]  pin_lag = 4'h0;
    logic [31:0] rd;
    int          n_errors = 0;
    int          n_compared = 0;

    always #25 ref_clk = ~ref_clk;

    stop_mode_controller i_stop_mode_controller (
        .ref_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .stop_pin, .key_wake,
        .volt_wake, .instr_addr, .resume_pc_q, .tg_clear_q, .mcyc_tick_q,
        .int_latch_q, .clk_ctrl_q
    );

    stop_pin_source i_stop_pin_source (
        .ref_clk, .want_high, .lag(pin_lag), .stop_pin
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results;
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic hang(input string what);
        n_errors++;
        $display("BAD %s expected answer seen timeout", what);
        results();
    endtask

    // Answer and read data taken at the rising edge, ahead of that edge's updates
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) hang("waitrequest");
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic st(input logic [1:0] e);
        bus(1'b0, STAT_OFS, 8'h00);
        chk("state", 16'(e), 16'(rd[3:2]));
    endtask

    task automatic wait_run;
        int n;
        for (n = 0; n < 300; n++) begin
            bus(1'b0, STAT_OFS, 8'h00);
            if (rd[3:2] == 2'b00) break;
        end
        if (n >= 300) hang("run state");
    endtask

    task automatic pin_is(input logic v);
        int n;
        for (n = 0; n < 12 && stop_pin !== v; n++) @(negedge ref_clk);
        if (n >= 12) hang("stop pin");
    endtask

    task automatic enter(input logic [7:0] sco, input logic [15:0] pc);
        int n;
        int seen;
        seen = 0;
        @(posedge ref_clk);
        instr_addr <= pc;
        bus(1'b1, SCO_OFS, sco);
        for (n = 0; n < 4; n++) begin
            @(negedge ref_clk);
            seen += int'(tg_clear_q === 1'b1);
        end
        chk("timing clear", 16'h1, 16'(seen));
        chk("resume pc", pc + 16'h2, resume_pc_q);
        chk("osc in stop", 16'({3'b001, sco[HOLD_BIT]}), 16'({clk_ctrl_q.hi_osc_en,
            clk_ctrl_q.lo_osc_en, clk_ctrl_q.core_hold, clk_ctrl_q.port_hold}));
        st(2'b01);
    endtask

    // Wake source drops mid warm-up; expect {hi, lo, hold, warm source}
    task automatic run_back(input int src, input logic [3:0] osc);
        int n;
        n = 0;
        @(posedge ref_clk);
        if (src == 0) want_high <= 1'b1;
        if (src == 1) key_wake <= 1'b1;
        if (src == 2) volt_wake <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (n == 8) begin
                want_high <= 1'b0;
                key_wake  <= 1'b0;
                volt_wake <= 1'b0;
            end
            @(negedge ref_clk);
            n++;
            if (n == 12) chk("warm osc", 16'(osc), 16'({clk_ctrl_q.hi_osc_en, clk_ctrl_q.lo_osc_en, clk_ctrl_q.core_hold, clk_ctrl_q.warmup_src_lo}));
        end while (tg_clear_q !== 1'b1 && n < 200);
        if (n >= 200) hang("wake");
        chk("warm length", 16'h1, 16'(n > (2 << WU_SHIFT) && n < (2 << WU_SHIFT) + 14));
        st(2'b00);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        bus(1'b0, WCD_OFS, 8'h00);
        chk("duration reset", 16'(WCD_RST), 16'(rd));
        @(posedge ref_clk);
        avs_byteenable <= 4'h0;
        bus(1'b1, WCD_OFS, 8'h55);
        avs_byteenable <= 4'hF;
        bus(1'b0, WCD_OFS, 8'h00);
        chk("masked write", 16'(WCD_RST), 16'(rd));
        bus(1'b1, 6'h20, 8'hA5);
        bus(1'b0, 6'h20, 8'h00);
        chk("unmapped", 16'h0, 16'(rd));
        // Short warm-up keeps every wake under fifty cycles
        bus(1'b1, WCD_OFS, 8'h02);
    endtask

    task automatic t_edge;
        int n;
        @(posedge ref_clk);
        want_high <= 1'b1;
        pin_is(1'b1);
        enter(8'h80, 16'h1234);
        @(posedge ref_clk);
        want_high <= 1'b0;
        repeat (8) @(negedge ref_clk);
        st(2'b01);
        chk("int latch", 16'h1, 16'(int_latch_q));
        run_back(0, 4'hA);
        for (n = 0; n < 4; n++) begin
            @(negedge ref_clk);
            chk("gear tick", 16'h1, 16'(mcyc_tick_q));
        end
        bus(1'b1, INT_OFS, 8'h01);
        bus(1'b0, INT_OFS, 8'h00);
        chk("latch clear", 16'h0, 16'(rd[0]));
    endtask

    task automatic t_level;
        @(posedge ref_clk);
        want_high <= 1'b1;
        pin_is(1'b1);
        bus(1'b1, SCO_OFS, 8'hC0);
        repeat (3) @(negedge ref_clk);
        st(2'b00);
        @(posedge ref_clk);
        want_high <= 1'b0;
        pin_lag   <= 4'h3;
        pin_is(1'b0);
        enter(8'hC0, 16'hFFFE);
        run_back(0, 4'hA);
        pin_lag <= 4'h0;
    endtask

    task automatic t_modes;
        logic [7:0] mv [3] = '{8'h00, 8'h05, 8'h02};
        logic [3:0] ev [3] = '{4'hA, 4'hE, 4'h7};
        int i;
        int ticks;
        bus(1'b1, WCC_OFS, 8'h01);
        for (i = 0; i < 3; i++) begin
            bus(1'b1, MODE_OFS, mv[i]);
            enter(8'h90, 16'(i * 16'h0400));
            run_back(1 + i % 2, ev[i]);
        end
        chk("low clocks", 16'h1, 16'({clk_ctrl_q.cpu_clk_gear, clk_ctrl_q.wdt_clk_low}));
        bus(1'b1, MODE_OFS, 8'h05);
        repeat (2) @(negedge ref_clk);
        chk("dual clocks", 16'h3, 16'({clk_ctrl_q.cpu_clk_gear, clk_ctrl_q.wdt_clk_low}));
        bus(1'b1, MODE_OFS, 8'h02);
        repeat (2) @(negedge ref_clk);
        ticks = 0;
        repeat (8) begin
            @(negedge ref_clk);
            ticks += int'(mcyc_tick_q === 1'b1);
        end
        chk("low ticks", 16'h2, 16'(ticks));
    endtask

    task automatic t_reset_stop;
        enter(8'h80, 16'h0100);
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk("reset warm", 16'h3, 16'({clk_ctrl_q.hi_osc_en, clk_ctrl_q.core_hold}));
        st(2'b11);
        wait_run();
        chk("single run", 16'h2, 16'({clk_ctrl_q.hi_osc_en, clk_ctrl_q.lo_osc_en}));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        st(2'b11);
        wait_run();
        t_regs();
        t_edge();
        t_level();
        t_modes();
        t_reset_stop();
        results();
    end
endmodule

`default_nettype wire
